// [fbo_ctrl.v]
// Purpose: host-side controller that drives a parallel NOR flash through its pins
// Assumes: flash pins are asynchronous; inputs from the flash are double-synchronised
// Notes: one request at a time; req_ready high when idle
`timescale 1ns/1ps
`default_nettype none
`include "fbo_regs.vh"
module fbo_ctrl #(
   parameter AW = 18,
   parameter DW = 16
) (
   input wire ref_clk,
   input wire resetn,
   input wire req_valid,
   input wire [1:0] req_cmd,
   input wire [AW-1:0] req_addr,
   input wire [DW-1:0] req_wdata,
   input wire req_byte_mode,
   output reg req_ready,
   output reg rsp_valid,
   output reg [DW-1:0] rsp_rdata,
   output reg flash_busy,
   output reg [AW-1:0] addr_pins,
   output reg select_n,
   output reg gate_n,
   output reg strobe_n,
   output reg reset_n_pin,
   output reg width_sel,
   input wire [DW-1:0] data_pins_in,
   output reg [DW-1:0] data_pins_out,
   output reg [DW-1:0] data_pins_oe,
   input wire op_done_n
);
   localparam ST_IDLE = 3'h0;
   localparam ST_READ = 3'h1;
   localparam ST_WRITE = 3'h2;
   localparam ST_WREC = 3'h3;
   localparam ST_RST = 3'h4;
   localparam ST_RWAIT = 3'h5;
   localparam integer RP_INT = `FBO_RESET_PULSE_MIN_CYC;
   localparam integer RH_INT = `FBO_RESET_TO_READ_CYC;
   localparam integer CE_INT = `FBO_SELECT_ACCESS_CYC;
   localparam integer WP_INT = `FBO_WRITE_PULSE_CYC;
   // counts fit the eight-bit timer; cut to its width on purpose
   localparam [7:0] RP_CYC = RP_INT[7:0];
   localparam [7:0] RH_CYC = RH_INT[7:0];
   localparam [7:0] CE_CYC = CE_INT[7:0];
   localparam [7:0] WP_CYC = WP_INT[7:0];

   reg [2:0] state_reg;
   reg [DW-1:0] din_s1_reg;
   reg [DW-1:0] din_s2_reg;
   reg rdy_s1_reg;
   reg rdy_s2_reg;
   reg t_load;
   reg [7:0] t_value;
   wire t_done;

   fbo_timer #(.W(8)) u_timer (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .load(t_load),
      .value(t_value),
      .done(t_done)
   );

   // two-flop synchronisers for flash outputs
   always @(posedge ref_clk) begin
      din_s1_reg <= data_pins_in;
      din_s2_reg <= din_s1_reg;
      rdy_s1_reg <= op_done_n;
      rdy_s2_reg <= rdy_s1_reg;
   end

   // byte mode masks pins eight to fourteen; pin fifteen is the low address
   function [DW-1:0] fbo_oe_mask;
      input byte_mode;
      begin
         fbo_oe_mask = byte_mode ? {{(DW-8){1'b0}}, 8'hff} : {DW{1'b1}};
      end
   endfunction

   always @* begin
      t_load = 1'b0;
      t_value = 8'h00;
      case (state_reg)
         ST_IDLE: begin
            if (req_valid && req_ready) begin
               t_load = 1'b1;
               if (req_cmd == `FBO_CMD_RESET) begin
                  t_value = RP_CYC;
               end else if (req_cmd == `FBO_CMD_WRITE) begin
                  t_value = WP_CYC;
               end else begin
                  t_value = CE_CYC + 8'h02;
               end
            end
         end
         ST_WRITE: begin
            if (t_done) begin
               t_load = 1'b1;
               t_value = 8'h02;
            end
         end
         ST_RST: begin
            if (t_done) begin
               t_load = 1'b1;
               t_value = RH_CYC;
            end
         end
         default: begin
            t_load = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= {DW{1'b0}};
         flash_busy <= 1'b0;
         addr_pins <= {AW{1'b0}};
         select_n <= 1'b1;
         gate_n <= 1'b1;
         strobe_n <= 1'b1;
         reset_n_pin <= 1'b1;
         width_sel <= 1'b1;
         data_pins_out <= {DW{1'b0}};
         data_pins_oe <= {DW{1'b0}};
      end else begin
         rsp_valid <= 1'b0;
         flash_busy <= ~rdy_s2_reg;
         case (state_reg)
            ST_IDLE: begin
               select_n <= 1'b1;
               gate_n <= 1'b1;
               strobe_n <= 1'b1;
               data_pins_oe <= {DW{1'b0}};
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  addr_pins <= req_addr;
                  width_sel <= ~req_byte_mode;
                  if (req_cmd == `FBO_CMD_RESET) begin
                     reset_n_pin <= 1'b0;
                     state_reg <= ST_RST;
                  end else if (req_cmd == `FBO_CMD_WRITE) begin
                     select_n <= 1'b0;
                     strobe_n <= 1'b0;
                     data_pins_out <= req_wdata;
                     data_pins_oe <= fbo_oe_mask(req_byte_mode);
                     if (req_byte_mode) begin
                        data_pins_out[DW-1] <= req_wdata[DW-1];
                        data_pins_oe[DW-1] <= 1'b1;
                     end
                     state_reg <= ST_WRITE;
                  end else begin
                     select_n <= 1'b0;
                     gate_n <= 1'b0;
                     if (req_byte_mode) begin
                        data_pins_out[DW-1] <= req_wdata[DW-1];
                        data_pins_oe[DW-1] <= 1'b1;
                     end
                     state_reg <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               if (t_done) begin
                  // same timing for array, identifier and status
                  rsp_rdata <= width_sel ? din_s2_reg : {{(DW-8){1'b0}}, din_s2_reg[7:0]};
                  rsp_valid <= 1'b1;
                  select_n <= 1'b1;
                  gate_n <= 1'b1;
                  data_pins_oe <= {DW{1'b0}};
                  state_reg <= ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (t_done) begin
                  strobe_n <= 1'b1;
                  state_reg <= ST_WREC;
               end
            end
            ST_WREC: begin
               if (t_done) begin
                  select_n <= 1'b1;
                  data_pins_oe <= {DW{1'b0}};
                  rsp_valid <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_RST: begin
               if (t_done) begin
                  reset_n_pin <= 1'b1;
                  state_reg <= ST_RWAIT;
               end
            end
            ST_RWAIT: begin
               if (t_done && rdy_s2_reg) begin
                  rsp_valid <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // fbo_ctrl
`default_nettype wire

// [fbo_regs.vh]
// Purpose: constants for the flash bus operation controller
// Assumes: 200 MHz ref_clk, 5 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef FBO_REGS_VH
`define FBO_REGS_VH
`define FBO_CLK_NS 5
`define FBO_RESET_PULSE_MIN_NS 500
`define FBO_RESET_PULSE_MIN_CYC ((`FBO_RESET_PULSE_MIN_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS)
`define FBO_RESET_TO_READ_NS 50
`define FBO_RESET_TO_READ_CYC ((`FBO_RESET_TO_READ_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS)
`define FBO_SELECT_ACCESS_NS 70
`define FBO_SELECT_ACCESS_CYC ((`FBO_SELECT_ACCESS_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS)
`define FBO_WRITE_PULSE_NS 40
`define FBO_WRITE_PULSE_CYC ((`FBO_WRITE_PULSE_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS)
`define FBO_CMD_READ 2'h0
`define FBO_CMD_WRITE 2'h1
`define FBO_CMD_RESET 2'h2
`endif

// [fbo_timer.v]
// Purpose: loadable down counter giving a done level
// Assumes: single clock domain
// Notes: done is high when the count reaches zero
`timescale 1ns/1ps
`default_nettype none
module fbo_timer #(
   parameter W = 8
) (
   input wire ref_clk,
   input wire resetn,
   input wire load,
   input wire [W-1:0] value,
   output wire done
);
   reg [W-1:0] cnt_reg;
   always @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_reg <= {W{1'b0}};
      end else if (load) begin
         cnt_reg <= value;
      end else if (cnt_reg != {W{1'b0}}) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign done = (cnt_reg == {W{1'b0}});
endmodule // fbo_timer
`default_nettype wire

// [fbo_ctrl_sva.sv]
// Purpose: port checker for fbo_ctrl
// Assumes: one clock, resetn synchronous active low
// Notes: counters measure pin low and high spans
`timescale 1ns/1ps
`default_nettype none
`include "fbo_regs.vh"
module fbo_ctrl_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic flash_busy,
   input wire logic select_n,
   input wire logic gate_n,
   input wire logic strobe_n,
   input wire logic reset_n_pin,
   input wire logic width_sel,
   input wire logic [15:0] data_pins_oe,
   input wire logic op_done_n
);
   logic [7:0] lo_reg, hi_reg, sel_reg;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge ref_clk) begin
      lo_reg <= (!resetn || reset_n_pin) ? 8'h00 : lo_reg + 8'h01;
      hi_reg <= !resetn ? 8'hff : !reset_n_pin ? 8'h00 : hi_reg + {7'h00, hi_reg != 8'hff};
      sel_reg <= (!resetn || select_n) ? 8'h00 : sel_reg + 8'h01;
   end
   chk_read_levels: assert property (!gate_n |-> !select_n && strobe_n && reset_n_pin)
      else $error("bad read levels");
   chk_write_levels: assert property (!strobe_n |-> !select_n && gate_n)
      else $error("bad write levels");
   chk_word_drive: assert property (!strobe_n && width_sel |-> data_pins_oe == 16'hffff)
      else $error("word write not driven");
   chk_reset_quiet: assert property (!reset_n_pin |-> select_n && data_pins_oe == 16'h0000)
      else $error("cycle during reset");
   chk_reset_width: assert property ($rose(reset_n_pin) |-> lo_reg >= `FBO_RESET_PULSE_MIN_CYC)
      else $error("reset pulse short");
   chk_reset_read: assert property ($fell(gate_n) |-> hi_reg >= `FBO_RESET_TO_READ_CYC)
      else $error("read too soon after reset");
   chk_access_wait: assert property ($rose(gate_n) |-> sel_reg >= `FBO_SELECT_ACCESS_CYC)
      else $error("read ended before access time");
   chk_busy_seen: assert property (!op_done_n [*5] |-> flash_busy)
      else $error("busy not shown");
endmodule // fbo_ctrl_chk
bind fbo_ctrl fbo_ctrl_chk fbo_ctrl_chk_inst (.ref_clk, .resetn, .flash_busy, .select_n,
   .gate_n, .strobe_n, .reset_n_pin, .width_sel, .data_pins_oe, .op_done_n);
`default_nettype wire

// [fbo_flash_model.sv]
// Purpose: behavioural flash device on the pins
// Assumes: sampled on ref_clk, 16 words of array
// Notes: undriven data lines show the inverse of their last level
`timescale 1ns/1ps
`default_nettype none
module fbo_flash_model (
   input wire logic ref_clk,
   input wire logic [17:0] addr_pins,
   input wire logic select_n,
   input wire logic gate_n,
   input wire logic strobe_n,
   input wire logic reset_n_pin,
   input wire logic width_sel,
   input wire logic [15:0] data_pins_out,
   input wire logic [15:0] data_pins_oe,
   output logic [15:0] data_pins_in,
   output logic op_done_n
);
   logic [15:0] mem [0:15];
   logic [15:0] last, val, en;
   logic [3:0] idx;
   logic stb_q, id_mode;
   int acc, busy;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'ha5c0 + 16'(i);
      {last, stb_q, id_mode, acc, busy} = '0;
   end
   assign idx = width_sel ? addr_pins[3:0] : {addr_pins[2:0], data_pins_out[15]};
   assign val = busy != 0 ? 16'h0044 : id_mode ? 16'h00c3 : mem[idx];
   assign en = (!select_n && !gate_n && reset_n_pin && acc >= 14) ?
      (width_sel ? 16'hffff : 16'h00ff) : 16'h0000;
   assign data_pins_in = (data_pins_oe & data_pins_out) | (~data_pins_oe & ((en & val) | (~en & ~last)));
   assign op_done_n = busy == 0;
   always @(posedge ref_clk) begin
      last <= data_pins_in;
      stb_q <= strobe_n;
      acc <= (select_n || !reset_n_pin) ? 0 : acc + 1;
      if (!reset_n_pin) begin
         id_mode <= 1'b0;
         busy <= (busy != 0) ? 20 : 0;
      end else begin
         if (busy != 0) busy <= busy - 1;
         if (strobe_n && !stb_q && !select_n && gate_n) begin
            if (data_pins_out[7:0] == 8'h90) id_mode <= 1'b1;
            else begin
               mem[idx] <= width_sel ? data_pins_out : {8'h00, data_pins_out[7:0]};
               busy <= 30;
            end
         end
      end
   end
endmodule // fbo_flash_model
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for fbo_ctrl
// Assumes: 200 MHz ref_clk, flash model on the pins
// Notes: table rows first, then reset cases
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, resetn, req_valid, req_byte_mode, b;
   logic [1:0] req_cmd, c;
   logic [17:0] req_addr, a;
   logic [15:0] req_wdata, w, e, got;
   wire logic req_ready, rsp_valid, flash_busy, select_n, gate_n, strobe_n, reset_n_pin;
   wire logic width_sel, op_done_n;
   wire logic [17:0] addr_pins;
   wire logic [15:0] rsp_rdata, data_pins_in, data_pins_out, data_pins_oe;
   int miscompares = 0, n_tests = 0;
   logic [52:0] rows [0:8] = '{{2'h1, 18'h1, 16'h1234, 1'b0, 16'h0},
      {2'h0, 18'h1, 16'h0, 1'b0, 16'h0044}, {2'h0, 18'h1, 16'h0, 1'b0, 16'h1234},
      {2'h0, 18'h2, 16'h0, 1'b0, 16'ha5c2}, {2'h1, 18'h0, 16'h8056, 1'b1, 16'h0},
      {2'h0, 18'h0, 16'h8000, 1'b1, 16'h0044}, {2'h0, 18'h0, 16'h8000, 1'b1, 16'h0056},
      {2'h1, 18'h0, 16'h0090, 1'b0, 16'h0}, {2'h0, 18'h5, 16'h0, 1'b0, 16'h00c3}};
   fbo_ctrl fbo_ctrl_inst (.ref_clk, .resetn, .req_valid, .req_cmd, .req_addr, .req_wdata,
      .req_byte_mode, .req_ready, .rsp_valid, .rsp_rdata, .flash_busy, .addr_pins, .select_n,
      .gate_n, .strobe_n, .reset_n_pin, .width_sel, .data_pins_in, .data_pins_out,
      .data_pins_oe, .op_done_n);
   fbo_flash_model fbo_flash_model_inst (.ref_clk, .addr_pins, .select_n, .gate_n, .strobe_n,
      .reset_n_pin, .width_sel, .data_pins_out, .data_pins_oe, .data_pins_in, .op_done_n);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_req(input logic [1:0] rc, input logic [17:0] ra, input logic [15:0] rw,
      input logic rb, output logic [15:0] rd);
      int n;
      {req_cmd, req_addr, req_wdata, req_byte_mode, req_valid} <= {rc, ra, rw, rb, 1'b1};
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      chk({15'h0, rsp_valid}, 16'h0001);
      rd = rsp_rdata;
      @(posedge ref_clk);
      chk({13'h0, select_n, gate_n, strobe_n}, 16'h0007);
   endtask
   task automatic test_done;
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
   initial begin
      {resetn, req_valid, req_cmd, req_addr, req_wdata, req_byte_mode} = '0;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         {c, a, w, b, e} = rows[i];
         do_req(c, a, w, b, got);
         if (c == 2'h0) chk(got, e);
      end
      do_req(2'h1, 18'h3, 16'h0007, 1'b0, got);
      do_req(2'h2, 18'h0, 16'h0, 1'b0, got);
      chk({15'h0, flash_busy}, 16'h0000);
      do_req(2'h0, 18'h2, 16'h0, 1'b0, got);
      chk(got, 16'ha5c2);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({13'h0, req_ready, select_n, reset_n_pin}, 16'h0003);
      resetn <= 1'b1;
      do_req(2'h0, 18'h1, 16'h0, 1'b0, got);
      chk(got, 16'h0056);
      do_req(2'h1, 18'h3, 16'h0007, 1'b0, got);
      test_done;
   end
endmodule // testbench
`default_nettype wire
